// ---- hw/pmsa_pkg.sv ----
// constants, field layout and frame timing of the management status/advertisement bank
//
// Behaviour
// - status bits 15..9 always read zero
// - status bit 8 always reads one
// - status bits 7 and 6 always read one
// - status bit 5 shows negotiation complete
// - remote fault bit sticky, cleared on read
// - status bit 3 always reads one
// - link bit latches low, refreshed on read
// - status bits 1 and 0 always zero
// - first identifier word is read-only identifier
// - second identifier: identifier bits, zero model, revision
// - next page bit writable, resets zero
// - remote fault code writable, clears on completion
// - pause field writable, resets to three
// - half duplex bit always reads zero
// - full duplex bit writable, resets one
// - registers reached by management frames, addresses 1-4
package pmsa_pkg;

   // register addresses
   localparam logic [4:0]  REG_STATUS      = 5'h01;
   localparam logic [4:0]  REG_IDENT_HIGH  = 5'h02;
   localparam logic [4:0]  REG_IDENT_LOW   = 5'h03;
   localparam logic [4:0]  REG_ADVERTISE   = 5'h04;

   // status field positions and the constant capability pattern
   localparam int          STAT_AN_DONE    = 5;
   localparam int          STAT_RFAULT     = 4;
   localparam int          STAT_LINK       = 2;
   localparam logic [15:0] STAT_FIXED      = 16'h01c8;

   // advertisement field positions and reset values
   localparam int          ADV_NEXT_PAGE   = 15;
   localparam int          ADV_RF_HI       = 13;
   localparam int          ADV_RF_LO       = 12;
   localparam int          ADV_PAUSE_HI    = 8;
   localparam int          ADV_PAUSE_LO    = 7;
   localparam int          ADV_FULL_DUPLEX = 5;
   localparam logic        RST_NEXT_PAGE   = 1'b0;
   localparam logic [1:0]  RST_RFAULT      = 2'h0;
   localparam logic [1:0]  RST_PAUSE       = 2'h3;
   localparam logic        RST_FULL_DUPLEX = 1'b1;

   // identifier fields
   localparam logic [5:0]  MODEL_NUMBER    = 6'h00;
   localparam logic [3:0]  REVISION_NUMBER = 4'h0;

   // management frame layout, in bits after the start pattern
   localparam logic [1:0]  OP_WRITE        = 2'h1;
   localparam logic [1:0]  OP_READ         = 2'h2;
   localparam logic [4:0]  HDR_BITS        = 5'h0c;
   localparam logic [4:0]  TA_BITS         = 5'h02;
   localparam logic [4:0]  DATA_BITS       = 5'h10;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_HDR  = 2'b01,
      ST_TA   = 2'b10,
      ST_DATA = 2'b11
   } pmsa_state_t;

endpackage : pmsa_pkg

// ---- hw/pmsa_regs.sv ----
// management frame slave holding the status, identifier and advertisement registers
`timescale 1ns/10ps
`default_nettype none

module pmsa_regs
   import pmsa_pkg::*;
#(
   parameter logic [15:0] OUI_HIGH = 16'h5a3c,   // arbitrary identifier value
   parameter logic [5:0]  OUI_LOW  = 6'h2b       // arbitrary identifier value
) (
   input  wire logic       clock,               // 25 MHz system clock
   input  wire logic       sys_rst,             // synchronous reset, active high
   input  wire logic       mdc,                 // management clock pin
   input  wire logic       mdio_i,              // management data pin, input side
   output logic            mdio_o,              // management data pin, output side
   output logic            mdio_oe,             // high while this block drives data
   input  wire logic [4:0] phy_addr,            // port address this slave answers to
   input  wire logic       an_complete,         // negotiation finished, level
   input  wire logic       remote_fault_det,    // remote fault seen, level or pulse
   input  wire logic       link_up,             // physical link up, level
   output logic            adv_next_page,       // advertised next page ability
   output logic [1:0]      adv_remote_fault,    // advertised remote fault code
   output logic [1:0]      adv_pause,           // advertised pause ability
   output logic            adv_full_duplex      // advertised full duplex ability
);

   // pin synchronisers and edge history
   logic        mdc_s1_reg;
   logic        mdc_s2_reg;
   logic        mdc_d_reg;
   logic        mdio_s1_reg;
   logic        mdio_s2_reg;

   // frame tracking
   pmsa_state_t state_reg;
   pmsa_state_t state_next;
   logic [4:0]  cnt_reg;
   logic [4:0]  cnt_next;
   logic        prev_bit_reg;
   logic [11:0] hdr_reg;
   logic [11:0] hdr_next;
   logic [15:0] wr_reg;
   logic [15:0] wr_next;
   logic        wr_go_reg;
   logic        rd_go_reg;
   logic [4:0]  reg_addr_reg;

   // read path
   logic [16:0] rd_shift_reg;
   logic        drive_arm_reg;

   // register state
   logic        rf_latch_reg;
   logic        link_latch_reg;
   logic        an_done_d_reg;
   logic        np_reg;
   logic [1:0]  rf_adv_reg;
   logic [1:0]  pause_reg;
   logic        fd_reg;

   // decode wires
   logic        mdc_rise;
   logic        mdc_fall;
   logic        hdr_last;
   logic        ta_last;
   logic        data_last;
   logic        start_seen;
   logic [1:0]  hdr_op;
   logic [4:0]  hdr_phy;
   logic [4:0]  hdr_reg_sel;
   logic        hdr_done;
   logic        reg_mapped;
   logic        rd_hit;
   logic        status_read;
   logic        adv_write;
   logic        an_done_rise;
   logic [15:0] status_word;
   logic [15:0] ident_high_word;
   logic [15:0] ident_low_word;
   logic [15:0] adv_word;
   logic [15:0] rd_word;

   // both pins come from another domain, so two flops before any logic looks at them
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         mdc_s1_reg  <= 1'b0;
         mdc_s2_reg  <= 1'b0;
         mdc_d_reg   <= 1'b0;
         mdio_s1_reg <= 1'b1;
         mdio_s2_reg <= 1'b1;
      end else begin
         mdc_s1_reg  <= mdc;
         mdc_s2_reg  <= mdc_s1_reg;
         mdc_d_reg   <= mdc_s2_reg;
         mdio_s1_reg <= mdio_i;
         mdio_s2_reg <= mdio_s1_reg;
      end
   end

   // edges of the management clock; it must stay well below a quarter of clock
   assign mdc_rise = mdc_s2_reg & ~mdc_d_reg;
   assign mdc_fall = ~mdc_s2_reg & mdc_d_reg;

   // frame decode; a missing preamble is fine, only the 0 then 1 start matters
   assign start_seen  = ~prev_bit_reg & mdio_s2_reg;
   assign hdr_next    = {hdr_reg[10:0], mdio_s2_reg};
   assign wr_next     = {wr_reg[14:0], mdio_s2_reg};
   assign hdr_op      = hdr_next[11:10];
   assign hdr_phy     = hdr_next[9:5];
   assign hdr_reg_sel = hdr_next[4:0];
   assign hdr_last    = (cnt_reg == HDR_BITS - 5'h01);
   assign ta_last     = (cnt_reg == TA_BITS - 5'h01);
   assign data_last   = (cnt_reg == DATA_BITS - 5'h01);
   assign hdr_done    = mdc_rise & (state_reg == ST_HDR) & hdr_last;
   // only this bank's addresses answer; the rest of 0-31 belongs to other banks
   assign reg_mapped  = (hdr_reg_sel >= REG_STATUS) & (hdr_reg_sel <= REG_ADVERTISE);
   assign rd_hit      = hdr_done & (hdr_op == OP_READ) & (hdr_phy == phy_addr)
                        & reg_mapped;
   assign status_read = rd_hit & (hdr_reg_sel == REG_STATUS);
   assign adv_write   = mdc_rise & (state_reg == ST_DATA) & data_last & wr_go_reg
                        & (reg_addr_reg == REG_ADVERTISE);

   // frame state sequencing, one step per rising management clock edge
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      if (mdc_rise) begin
         cnt_next = cnt_reg + 5'h01;
         unique case (state_reg)
            ST_IDLE: begin
               cnt_next = 5'h00;
               if (start_seen) begin
                  state_next = ST_HDR;
               end
            end
            ST_HDR: begin
               if (hdr_last) begin
                  state_next = ST_TA;
                  cnt_next   = 5'h00;
               end
            end
            ST_TA: begin
               if (ta_last) begin
                  state_next = ST_DATA;
                  cnt_next   = 5'h00;
               end
            end
            ST_DATA: begin
               if (data_last) begin
                  state_next = ST_IDLE;
                  cnt_next   = 5'h00;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_reg <= ST_IDLE;
         cnt_reg   <= 5'h00;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
      end
   end

   // bit history and shift registers for the incoming frame
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         prev_bit_reg <= 1'b1;
         hdr_reg      <= 12'h000;
         wr_reg       <= 16'h0000;
      end else if (mdc_rise) begin
         // held at one through a frame so its last data bits cannot fake a start
         prev_bit_reg <= (state_reg == ST_IDLE) ? mdio_s2_reg : 1'b1;
         hdr_reg      <= (state_reg == ST_HDR) ? hdr_next : hdr_reg;
         wr_reg       <= (state_reg == ST_DATA) ? wr_next : wr_reg;
      end
   end

   // command captured when the header completes
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         wr_go_reg    <= 1'b0;
         rd_go_reg    <= 1'b0;
         reg_addr_reg <= 5'h00;
      end else if (hdr_done) begin
         wr_go_reg    <= (hdr_op == OP_WRITE) & (hdr_phy == phy_addr);
         rd_go_reg    <= rd_hit;
         reg_addr_reg <= hdr_reg_sel;
      end
   end

   // read words; every fixed bit comes from a constant, so writes cannot touch it
   assign status_word = STAT_FIXED
                        | (16'(an_complete)    << STAT_AN_DONE)
                        | (16'(rf_latch_reg)   << STAT_RFAULT)
                        | (16'(link_latch_reg) << STAT_LINK);
   assign ident_high_word = OUI_HIGH;
   assign ident_low_word  = {OUI_LOW, MODEL_NUMBER, REVISION_NUMBER};
   assign adv_word = (16'(np_reg) << ADV_NEXT_PAGE)
                     | (16'(rf_adv_reg) << ADV_RF_LO)
                     | (16'(pause_reg) << ADV_PAUSE_LO)
                     | (16'(fd_reg) << ADV_FULL_DUPLEX);
   assign rd_word = (hdr_reg_sel == REG_STATUS)     ? status_word :
                    (hdr_reg_sel == REG_IDENT_HIGH) ? ident_high_word :
                    (hdr_reg_sel == REG_IDENT_LOW)  ? ident_low_word :
                    adv_word;

   // read drive: zero in the second turnaround bit, then data msb first, on falling edges
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rd_shift_reg  <= 17'h00000;
         drive_arm_reg <= 1'b0;
         mdio_o        <= 1'b1;
         mdio_oe       <= 1'b0;
      end else begin
         if (rd_hit) begin
            rd_shift_reg <= {1'b0, rd_word};
         end else if (mdc_fall & drive_arm_reg) begin
            rd_shift_reg <= {rd_shift_reg[15:0], 1'b0};
         end
         if (mdc_rise & (state_reg == ST_TA) & ~ta_last & rd_go_reg) begin
            drive_arm_reg <= 1'b1;
         end else if (mdc_rise & (state_reg == ST_DATA) & data_last) begin
            drive_arm_reg <= 1'b0;
         end
         if (mdc_fall) begin
            mdio_o  <= drive_arm_reg ? rd_shift_reg[16] : 1'b1;
            mdio_oe <= drive_arm_reg;
         end
      end
   end

   // status latches: an event in the cycle of the read wins over the clear
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rf_latch_reg   <= 1'b0;
         link_latch_reg <= 1'b0;
      end else begin
         rf_latch_reg   <= remote_fault_det | (rf_latch_reg & ~status_read);
         // a link drop holds low until software has seen it
         link_latch_reg <= link_up & (link_latch_reg | status_read);
      end
   end

   // completion edge that retires the advertised fault code
   assign an_done_rise = an_complete & ~an_done_d_reg;

   // advertisement fields; a write in the cycle of completion wins
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         an_done_d_reg <= 1'b0;
         np_reg        <= RST_NEXT_PAGE;
         rf_adv_reg    <= RST_RFAULT;
         pause_reg     <= RST_PAUSE;
         fd_reg        <= RST_FULL_DUPLEX;
      end else begin
         an_done_d_reg <= an_complete;
         if (adv_write) begin
            np_reg     <= wr_next[ADV_NEXT_PAGE];
            rf_adv_reg <= wr_next[ADV_RF_HI:ADV_RF_LO];
            pause_reg  <= wr_next[ADV_PAUSE_HI:ADV_PAUSE_LO];
            fd_reg     <= wr_next[ADV_FULL_DUPLEX];
         end else if (an_done_rise) begin
            rf_adv_reg <= RST_RFAULT;
         end
      end
   end

   // advertised abilities toward the negotiation function
   assign adv_next_page    = np_reg;
   assign adv_remote_fault = rf_adv_reg;
   assign adv_pause        = pause_reg;
   assign adv_full_duplex  = fd_reg;

endmodule : pmsa_regs

`default_nettype wire

// ---- verification/pmsa_regs_sva.sv ----
// checker for frame drive timing and advertisement outputs
`timescale 1ns/10ps
`default_nettype none

module pmsa_sva
   import pmsa_pkg::*;
(
   input wire logic       clock,            // system clock
   input wire logic       sys_rst,          // sync reset
   input wire logic       mdc,              // mgmt clock pin
   input wire logic       an_complete,      // negotiation done
   input wire logic       mdio_o,           // data to pin
   input wire logic       mdio_oe,          // pin enable
   input wire logic       adv_next_page,    // next page
   input wire logic [1:0] adv_remote_fault, // fault code
   input wire logic [1:0] adv_pause,        // pause
   input wire logic       adv_full_duplex   // full duplex
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);

   // edge checks assume the station keeps each mdc phase at six clocks
   chk_reset_values: assert property (
      $fell(sys_rst) |-> adv_pause == 2'h3 && adv_full_duplex && !adv_next_page
         && adv_remote_fault == 2'h0 && !mdio_oe)
      else $error("outputs not at reset values");
   chk_fault_clear: assert property (
      $rose(an_complete) |-> ##[1:2] adv_remote_fault == 2'h0)
      else $error("fault code kept after completion");
   chk_drive_start: assert property ($rose(mdio_oe) |-> !mdio_o)
      else $error("turnaround bit not zero");
   chk_drive_len: assert property ($rose(mdio_oe) |-> mdio_oe [*8])
      else $error("read drive too short");
   chk_idle_high: assert property (!mdio_oe |-> mdio_o)
      else $error("data not high while released");
   chk_oe_edge: assert property ($changed(mdio_oe) |-> !mdc)
      else $error("enable moved in mdc high phase");
   chk_adv_edge: assert property (
      $changed(adv_pause) || $changed(adv_next_page) || $changed(adv_full_duplex) |-> mdc)
      else $error("advertisement moved outside a write");
   chk_adv_quiet: assert property (
      mdio_oe |-> $stable(adv_pause) && $stable(adv_next_page) && $stable(adv_full_duplex))
      else $error("advertisement moved during a read");
endmodule : pmsa_sva

bind pmsa_regs pmsa_sva u_pmsa_sva (
   .clock(clock), .sys_rst(sys_rst), .mdc(mdc), .an_complete(an_complete),
   .mdio_o(mdio_o), .mdio_oe(mdio_oe), .adv_next_page(adv_next_page),
   .adv_remote_fault(adv_remote_fault), .adv_pause(adv_pause),
   .adv_full_duplex(adv_full_duplex));

`default_nettype wire

// ---- verification/pmsa_host.sv ----
// station model running management frames on mdc and mdio
`timescale 1ns/10ps
`default_nettype none

module pmsa_host
   import pmsa_pkg::*;
(
   input  wire logic clock,  // system clock
   input  wire logic mdio_w, // resolved data wire
   output var logic  mdc,    // mgmt clock, still between frames
   output var logic  h_d,    // station data
   output var logic  h_oe    // high while station drives
);
   // idle: clock low, data released to the pull-up
   initial begin
      mdc  = 1'b0;
      h_d  = 1'b1;
      h_oe = 1'b0;
   end

   // six clocks a phase, well above the three-clock minimum
   task automatic half;
      repeat (6) @(negedge clock);
   endtask : half

   // preamble ones, start, op, addresses, turnaround, data; bits move on mdc low
   task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
      logic [33:0] f;
      f  = {4'hd, op, pa, ra, 2'h2, wd};
      rd = 16'h0;
      // one clock of gap so h_oe is never lowered and raised in one time step
      @(negedge clock);
      for (int i = 33; i >= 0; i--) begin
         h_d  = f[i];
         h_oe = !(op == OP_READ && i < 18);
         half();
         mdc  = 1'b1;
         if (i < 16) rd[i] = mdio_w;
         half();
         mdc  = 1'b0;
      end
      h_oe = 1'b0;
   endtask : xfer
endmodule : pmsa_host

`default_nettype wire

// ---- verification/pmsa_regs_tb_top.sv ----
// self-checking bench for the status, identifier and advertisement bank
`timescale 1ns/10ps
`default_nettype none

module pmsa_regs_tb_top
   import pmsa_pkg::*;
;
   localparam logic [4:0] PA = 5'h0b; // port address under test
   logic        clock, sys_rst, an_complete, remote_fault_det, link_up;
   logic        mdc, h_d, h_oe, mdio_o, mdio_oe, adv_next_page, adv_full_duplex;
   logic [1:0]  adv_remote_fault, adv_pause;
   logic [15:0] rv;
   int          error_cnt, cmp_count, cyc;
   // wire level: device, else station, else the pull-up
   wire logic        mdio_w   = mdio_oe ? mdio_o : (h_oe ? h_d : 1'b1);
   wire logic [15:0] adv_view = {adv_next_page, 1'b0, adv_remote_fault, 3'h0,
                                 adv_pause, 1'b0, adv_full_duplex, 5'h0};

   pmsa_regs #(.OUI_HIGH(16'h3c5a), .OUI_LOW(6'h15)) u_pmsa_regs (
      .clock(clock), .sys_rst(sys_rst), .mdc(mdc), .mdio_i(mdio_w), .mdio_o(mdio_o),
      .mdio_oe(mdio_oe), .phy_addr(PA), .an_complete(an_complete),
      .remote_fault_det(remote_fault_det), .link_up(link_up),
      .adv_next_page(adv_next_page), .adv_remote_fault(adv_remote_fault),
      .adv_pause(adv_pause), .adv_full_duplex(adv_full_duplex));
   pmsa_host u_pmsa_host (.clock(clock), .mdio_w(mdio_w), .mdc(mdc), .h_d(h_d), .h_oe(h_oe));

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic rd(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] exp);
      u_pmsa_host.xfer(OP_READ, pa, ra, 16'h0, rv);
      chk(rv, exp);
   endtask : rd

   task automatic wr(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                     input logic [15:0] wd);
      u_pmsa_host.xfer(op, pa, ra, wd, rv);
   endtask : wr

   task automatic t_reset;
      sys_rst = 1'b1;
      repeat (4) @(negedge clock);
      sys_rst = 1'b0;
      repeat (3) @(negedge clock);
      chk(adv_view, 16'h01a0);
      // the station clears isolate in the control word before using the link
      wr(OP_WRITE, PA, 5'h00, 16'h1000);
      rd(PA, REG_ADVERTISE, 16'h01a0);
      $display("test reset done");
   endtask : t_reset

   // every pause and fault code, with fixed bits written as ones
   task automatic t_adv;
      logic [1:0]  k;
      logic [15:0] e;
      for (int i = 0; i < 4; i++) begin
         k = 2'(i);
         e = {k[0], 1'b0, k, 3'h0, k, 1'b0, k[1], 5'h0};
         wr(OP_WRITE, PA, REG_ADVERTISE, {k[0], 1'b1, k, 3'h7, k, 1'b1, k[1], 5'h1f});
         chk(adv_view, e);
         rd(PA, REG_ADVERTISE, e);
      end
      $display("test advertise done");
   endtask : t_adv

   task automatic t_stat;
      wr(OP_WRITE, PA, REG_ADVERTISE, 16'h21a0);
      rd(PA, REG_STATUS, 16'h01c8);
      rd(PA, REG_STATUS, 16'h01cc);
      @(negedge clock);
      an_complete      = 1'b1;
      remote_fault_det = 1'b1;
      @(negedge clock);
      remote_fault_det = 1'b0;
      repeat (3) @(negedge clock);
      chk(adv_view, 16'h01a0);
      rd(PA, REG_STATUS, 16'h01fc);
      rd(PA, REG_STATUS, 16'h01ec);
      link_up = 1'b0;
      @(negedge clock);
      link_up = 1'b1;
      rd(PA, REG_STATUS, 16'h01e8);
      rd(PA, REG_STATUS, 16'h01ec);
      an_complete = 1'b0;
      $display("test status done");
   endtask : t_stat

   task automatic t_ident;
      rd(PA, REG_IDENT_HIGH, 16'h3c5a);
      rd(PA, REG_IDENT_LOW, 16'h5400);
      wr(OP_WRITE, PA, REG_IDENT_HIGH, 16'h0);
      wr(OP_WRITE, PA, REG_IDENT_LOW, 16'hffff);
      wr(OP_WRITE, PA, REG_STATUS, 16'h0);
      rd(PA, REG_IDENT_HIGH, 16'h3c5a);
      rd(PA, REG_IDENT_LOW, 16'h5400);
      rd(PA, REG_STATUS, 16'h01cc);
      $display("test ident done");
   endtask : t_ident

   // foreign port, unmapped places and a bad op must leave the wire and state alone
   task automatic t_refuse;
      rd(PA ^ 5'h01, REG_STATUS, 16'hffff);
      rd(PA, 5'h05, 16'hffff);
      rd(PA, 5'h00, 16'hffff);
      wr(2'h0, PA, REG_ADVERTISE, 16'h0);
      wr(OP_WRITE, PA ^ 5'h01, REG_ADVERTISE, 16'h0);
      rd(PA, REG_ADVERTISE, 16'h01a0);
      $display("test refuse done");
   endtask : t_refuse

   task automatic results;
      $display("counts cmp=%0d err=%0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : results

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   // a hang costs one mismatch and closes the run
   always @(posedge clock) begin
      cyc++;
      if (cyc == 30000) begin
         error_cnt++;
         results();
      end
   end

   initial begin
      an_complete      = 1'b0;
      remote_fault_det = 1'b0;
      link_up          = 1'b1;
      error_cnt        = 0;
      cmp_count        = 0;
      cyc              = 0;
      t_reset();
      t_adv();
      t_stat();
      t_ident();
      t_refuse();
      t_reset();
      results();
   end
endmodule : pmsa_regs_tb_top

`default_nettype wire
